//--- testbench/sdc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_host (
	output logic SCLK,
	output logic SELECT_N,
	output logic SI,
	input wire logic SO
);
	initial begin
		SCLK = 1'b0;
		SELECT_N = 1'b1;
		SI = 1'b0;
	end
	// Data line toggles between frames so a stale bit never looks valid
	always #80 if (SELECT_N) SI = ~SI;
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx,
		output logic flag);
		SELECT_N = 1'b0;
		#450;
		flag = SO;
		rx = 16'h0000;
		for (int i = 0; i < n; i++) begin
			SCLK = 1'b1;
			SI = tx[15 - (i % 16)];
			#40;
			rx = {rx[14:0], SO};
			SCLK = 1'b0;
			#40;
		end
		SELECT_N = 1'b1;
		#500;
	endtask : xfer
endmodule : sdc_host
`default_nettype wire

//--- testbench/sdc_slave_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_slave_assertions (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic SELECT_N,
	input wire logic SO_OUT,
	input wire logic SO_OE,
	input wire logic [12:0] DIAG_IN,
	input wire logic RESET_OUTPUT_N,
	input wire logic CH2_ON,
	input wire logic CH4_ON,
	input wire logic CH5_ON,
	input wire logic [1:0] SENSOR_THRESHOLD_SEL,
	input wire logic [1:0] SENSOR_LOAD_SEL
);
	wire logic [6:0] cfg = {CH2_ON, CH4_ON, CH5_ON, SENSOR_THRESHOLD_SEL, SENSOR_LOAD_SEL};
	default clocking @(posedge MCLK); endclocking
	default disable iff (!NRST);
	chk_oe_high: assert property (SELECT_N |-> !SO_OE)
		else $error("serial output driven while deselected");
	chk_oe_low: assert property (!SELECT_N |-> SO_OE)
		else $error("serial output released while selected");
	// Reset itself is the condition here, so this one is never disabled
	chk_rst_low: assert property (disable iff (1'b0) !NRST |-> !SO_OUT)
		else $error("serial output not low in reset");
	chk_rst_clear: assert property ($rose(NRST) |-> cfg == 7'h00)
		else $error("config outputs not cleared by reset");
	chk_cfg_hold: assert property ($changed(cfg) |-> SELECT_N)
		else $error("config changed inside a frame");
	chk_cfg_late: assert property ($rose(SELECT_N) |=> $stable(cfg))
		else $error("config changed before frame check");
	chk_wd_hold: assert property (!RESET_OUTPUT_N [*6] |=> $stable(cfg))
		else $error("config changed in watchdog reset");
	chk_flag_idle: assert property (
		$stable(DIAG_IN) [*5] ##0 $fell(SELECT_N) |-> SO_OUT == |DIAG_IN)
		else $error("status flag wrong at frame start");
	cov_write: cover property ($changed(cfg));
	cov_flag: cover property ($fell(SELECT_N) && SO_OUT);
	cov_wd: cover property ($rose(RESET_OUTPUT_N));
endmodule : sdc_slave_assertions
bind sdc_slave sdc_slave_assertions chk_i (.MCLK, .NRST, .SELECT_N, .SO_OUT, .SO_OE, .DIAG_IN,
	.RESET_OUTPUT_N, .CH2_ON, .CH4_ON, .CH5_ON, .SENSOR_THRESHOLD_SEL, .SENSOR_LOAD_SEL);
`default_nettype wire

//--- testbench/test_spi_diag_control_slave.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_diag_control_slave;
	logic MCLK = 1'b0;
	logic NRST = 1'b0;
	logic [12:0] DIAG_IN = 13'h0000;
	logic [4:0] SWITCH_ON_IN = 5'h00;
	logic WD_STATUS_IN = 1'b0;
	logic WD_TIMEOUT_IN = 1'b0;
	logic RESET_OUTPUT_N = 1'b1;
	logic SCLK, SELECT_N, SI, SO_OUT, SO_OE, CH2_ON, CH4_ON, CH5_ON;
	logic [1:0] SENSOR_THRESHOLD_SEL, SENSOR_LOAD_SEL;
	wire logic so_pin = SO_OE ? SO_OUT : 1'bz;
	wire logic [12:0] cfg_seen = {SENSOR_THRESHOLD_SEL, SENSOR_LOAD_SEL, 6'h00, CH5_ON, CH4_ON,
		CH2_ON};
	int fail_count = 0;
	int checked = 0;
	logic [31:0] lfsr = 32'h05B58538;
	logic [2:0] hdr;
	logic [12:0] cmd;
	logic [15:0] tx_tab [9] = '{16'h9A07, 16'h0000, 16'h2000, 16'h4000, 16'hA000, 16'h6000,
		16'h9FFF, 16'h9FFF, 16'h0000};
	int n_tab [9] = '{16, 16, 16, 16, 16, 16, 15, 17, 16};
	always #50 MCLK = ~MCLK;
	sdc_slave dut (.MCLK, .NRST, .SCLK, .SELECT_N, .SI, .SO_OUT, .SO_OE, .DIAG_IN, .SWITCH_ON_IN,
		.WD_STATUS_IN, .WD_TIMEOUT_IN, .RESET_OUTPUT_N, .CH2_ON, .CH4_ON, .CH5_ON,
		.SENSOR_THRESHOLD_SEL, .SENSOR_LOAD_SEL);
	sdc_host host (.SCLK, .SELECT_N, .SI, .SO(so_pin));
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : next_rand
	function automatic logic [15:0] reply();
		case (hdr[1:0])
			2'h0: return {hdr, cmd};
			2'h1: return {hdr, DIAG_IN};
			default: return {hdr, 6'h00, WD_TIMEOUT_IN, WD_STATUS_IN, SWITCH_ON_IN};
		endcase
	endfunction : reply
	task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : cmp
	task automatic cmp_bit(input string what, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask : cmp_bit
	task automatic cmp_cfg(input logic [12:0] e, input logic [12:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED config expected %h seen %h", e, g);
		end
	endtask : cmp_cfg
	task automatic finish_test();
		$display("checked %0d failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic step_inputs();
		@(posedge MCLK);
		#1;
		repeat (8) lfsr = next_rand(lfsr);
		DIAG_IN = (lfsr[3:0] > 4'h9) ? lfsr[16:4] : 13'h0000;
		{WD_TIMEOUT_IN, WD_STATUS_IN, SWITCH_ON_IN} = lfsr[23:17];
	endtask : step_inputs
	task automatic frame(input logic [15:0] tx, input int n);
		logic [15:0] rx;
		logic flag;
		logic [15:0] e;
		// Inputs need two edges through the synchronisers before a frame
		repeat (6) @(posedge MCLK);
		#1;
		e = RESET_OUTPUT_N ? reply() : {16{|DIAG_IN}};
		host.xfer(tx, n, rx, flag);
		cmp_bit("flag", |DIAG_IN, flag);
		if (n == 16)
			cmp("reply", e, rx);
		if (RESET_OUTPUT_N) begin
			if (n == 16 && tx[15:13] == 3'h4)
				cmd = {tx[12:9], 6'h00, tx[2:0]};
			hdr = (n == 16 && (tx[15:13] == 3'h4 || tx[15:13] < 3'h3)) ? tx[15:13] : 3'h1;
		end
		cmp_cfg(cmd, cfg_seen);
	endtask : frame
	initial begin
		#500000;
		fail_count++;
		finish_test();
	end
	initial begin
		hdr = 3'h0;
		cmd = 13'h0000;
		repeat (16) @(posedge MCLK);
		#1 NRST = 1'b1;
		foreach (tx_tab[i]) begin
			step_inputs();
			frame(tx_tab[i], n_tab[i]);
		end
		repeat (12) begin
			step_inputs();
			frame(lfsr[31:16], 16);
		end
		step_inputs();
		RESET_OUTPUT_N = 1'b0;
		frame(16'h9FFF, 16);
		step_inputs();
		RESET_OUTPUT_N = 1'b1;
		hdr = 3'h2;
		frame(16'h0000, 16);
		@(posedge MCLK);
		#1 NRST = 1'b0;
		repeat (3) @(posedge MCLK);
		cmp_bit("so in reset", 1'b0, SO_OUT);
		#1 NRST = 1'b1;
		cmd = 13'h0000;
		hdr = 3'h0;
		frame(16'h0000, 16);
		finish_test();
	end
endmodule : test_spi_diag_control_slave
`default_nettype wire

//--- verilog/sdc_link.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_link (
	input wire logic sclk,
	input wire logic nrst,
	input wire logic select_n,
	input wire logic si,
	input wire logic [15:0] reply,
	output logic [15:0] rx_word,
	output logic [4:0] bit_cnt,
	output logic frame_tag,
	output logic tx_bit,
	output logic tx_started
);
	typedef struct packed {
		logic [4:0] idx;
		logic tx;
	} sdc_rise_type;

	typedef struct packed {
		logic [4:0] cnt;
		logic [15:0] rx;
		logic tag;
	} sdc_fall_type;

	sdc_rise_type rs;
	sdc_rise_type next_rs;
	sdc_fall_type fs;
	sdc_fall_type next_fs;
	logic frame_rst_n;

	// Rising side ends with the frame; chip select high idles it
	assign frame_rst_n = nrst & ~select_n;

	always_comb begin
		next_rs = rs;
		if (rs.idx != sdc_pkg::CNT_SAT) begin
			next_rs.idx = rs.idx + 5'h01;
		end
		if (rs.idx < sdc_pkg::CNT_FULL) begin
			next_rs.tx = reply[4'hF - rs.idx[3:0]]; // see [RULE4] [RULE6]
		end else begin
			next_rs.tx = 1'b0;
		end
	end

	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rs <= '0;
		end else begin
			rs <= next_rs;
		end
	end

	// Count survives chip select rising so the core can check it afterwards
	always_comb begin
		next_fs = fs;
		if (rs.idx == sdc_pkg::CNT_ONE) begin
			next_fs.cnt = sdc_pkg::CNT_ONE;
			next_fs.rx = {15'h0000, si};
			next_fs.tag = ~fs.tag;
		end else begin
			if (fs.cnt != sdc_pkg::CNT_SAT) begin
				next_fs.cnt = fs.cnt + 5'h01; // see [RULE7]
			end
			next_fs.rx = {fs.rx[14:0], si}; // see [RULE4] [RULE6]
		end
	end

	always_ff @(negedge sclk or negedge nrst) begin
		if (!nrst) begin
			fs <= '0;
		end else begin
			fs <= next_fs;
		end
	end

	assign rx_word = fs.rx;
	assign bit_cnt = fs.cnt;
	assign frame_tag = fs.tag;
	assign tx_bit = rs.tx;
	assign tx_started = (rs.idx != 5'h00);
endmodule : sdc_link
`default_nettype wire

//--- verilog/sdc_pkg.sv
`default_nettype none
package sdc_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CNT_W = 5;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_SAT = 5'h11;
	localparam logic [4:0] CNT_ONE = 5'h01;
	// Frame layout
	localparam int RW_POS = 15;
	localparam int ADDR_HI = 14;
	localparam int ADDR_LO = 13;
	localparam int BODY_W = 13;
	localparam logic [1:0] ADDR_CMD = 2'h0;
	localparam logic [1:0] ADDR_DIAG = 2'h1;
	localparam logic [1:0] ADDR_STAT = 2'h2;
	// Command register fields and reset values
	localparam int THR_HI = 12;
	localparam int THR_LO = 11;
	localparam int LOAD_HI = 10;
	localparam int LOAD_LO = 9;
	localparam int CH5_POS = 2;
	localparam int CH4_POS = 1;
	localparam int CH2_POS = 0;
	localparam logic [1:0] THR_RESET = 2'h0;
	localparam logic [1:0] LOAD_RESET = 2'h0;
	localparam logic CH_RESET = 1'h0;
	localparam logic [15:0] REPLY_RESET = 16'h0000;
	// Status register fields, diagnosis width
	localparam int STAT_CH_W = 5;
	localparam int WD_STATUS_POS = 5;
	localparam int WD_TIMEOUT_POS = 6;
	localparam int STAT_W = 7;
	localparam int DIAG_W = 13;

	typedef enum logic [2:0] {
		SDC_SRC_CMD = 3'h1,
		SDC_SRC_DIAG = 3'h2,
		SDC_SRC_STAT = 3'h4
	} sdc_src_type;

	typedef struct packed {
		logic [1:0] thr;
		logic [1:0] load;
		logic ch2;
		logic ch4;
		logic ch5;
		sdc_src_type src;
		logic reply_rw;
		logic [1:0] reply_addr;
		logic [15:0] reply;
		logic sel_prev;
		logic wd_prev;
		logic tag_seen;
		logic diag_any;
	} sdc_core_type;
endpackage : sdc_pkg
`default_nettype wire

//--- verilog/sdc_slave.sv
// Contract
// [RULE1] Chip select high: clock and data ignored, serial output released.
// [RULE2] Chip select falling: serial output driven with the error flag.
// [RULE3] Chip select rising: check bit count and command, then execute.
// [RULE4] Sample input on falling clock, new output after rising clock.
// [RULE5] Host keeps serial clock low around every chip select edge.
// [RULE6] Both directions travel most significant bit first.
// [RULE7] Exactly sixteen bits per frame; any other length is discarded.
// [RULE8] Reply to a frame comes during the following frame.
// [RULE9] Valid: write command, read command, diagnosis or status; rest invalid.
// [RULE10] Valid reply repeats direction and address, then register content.
// [RULE11] Before first clock, output shows whether any diagnosis bit is set.
// [RULE12] Command register holds sensor setup and channel 2, 4, 5 enables.
// [RULE13] Diagnosis holds switch faults; status holds switch, watchdog bits.
// [RULE14] Power-on reset release puts every register in reset state.
// [RULE15] During power-on reset commands are ignored and output is low.
// [RULE16] First transfer after power-on reset carries command register.
// [RULE17] During watchdog reset commands ignored, output shows error flag.
// [RULE18] After watchdog reset release, next transfer carries status register; a frame ending at or after the release selects the reply instead.
// [RULE19] After a valid access, next transfer carries selected register.
// [RULE20] After an invalid frame, next transfer carries diagnosis register.
// [RULE21] Threshold field: 00 -50 mV, 01 -100 mV, 10 -500 mV, 11 -1 V.
// [RULE22] Load field: 00 75k, 01 4.5k, 10 2.2k, 11 1.2k ohm.
// [RULE23] Frame bit 15 is direction, bits 14 to 13 the address.
// [RULE24] Command register changes only at the validating chip select edge.
// [RULE25] Diagnosis and status are read only, fed by power and watchdog logic.
`timescale 1ns/1ps
`default_nettype none
module sdc_slave (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic SCLK,
	input wire logic SELECT_N,
	input wire logic SI,
	output logic SO_OUT,
	output logic SO_OE,
	input wire logic [12:0] DIAG_IN,
	input wire logic [4:0] SWITCH_ON_IN,
	input wire logic WD_STATUS_IN,
	input wire logic WD_TIMEOUT_IN,
	input wire logic RESET_OUTPUT_N,
	output logic CH2_ON,
	output logic CH4_ON,
	output logic CH5_ON,
	output logic [1:0] SENSOR_THRESHOLD_SEL,
	output logic [1:0] SENSOR_LOAD_SEL
);
	localparam int SYNC_W = sdc_pkg::DIAG_W + sdc_pkg::STAT_W + 2;
	localparam logic [SYNC_W-1:0] SYNC_RST = {2'h3, 20'h00000};

	sdc_pkg::sdc_core_type st;
	sdc_pkg::sdc_core_type next_st;

	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_out;
	logic sel_s;
	logic wd_s;
	logic [12:0] diag_s;
	logic [6:0] stat_s;
	logic [15:0] rx_word;
	logic [4:0] bit_cnt;
	logic frame_tag;
	logic tx_bit;
	logic tx_started;
	logic sel_rise;
	logic wd_rise;
	logic wd_active;
	logic frame_ok;
	logic f_rw;
	logic [1:0] f_addr;

	// Every pin that the core reads goes through two flops
	assign sync_in = {SELECT_N, RESET_OUTPUT_N, WD_TIMEOUT_IN, WD_STATUS_IN,
		SWITCH_ON_IN, DIAG_IN};

	sdc_sync #(
		.W(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk(MCLK),
		.rst_n(NRST),
		.d(sync_in),
		.q(sync_out)
	);

	assign diag_s = sync_out[12:0];
	assign stat_s = sync_out[19:13]; // see [RULE13] [RULE25]
	assign wd_s = sync_out[20];
	assign sel_s = sync_out[21];

	sdc_link u_link (
		.sclk(SCLK),
		.nrst(NRST),
		.select_n(SELECT_N),
		.si(SI),
		.reply(st.reply),
		.rx_word(rx_word),
		.bit_cnt(bit_cnt),
		.frame_tag(frame_tag),
		.tx_bit(tx_bit),
		.tx_started(tx_started)
	);

	// Only four direction/address pairs are legal
	function automatic logic access_ok(input logic rw, input logic [1:0] addr);
		if (rw) begin
			access_ok = (addr == sdc_pkg::ADDR_CMD); // see [RULE9]
		end else begin
			access_ok = (addr == sdc_pkg::ADDR_CMD) || (addr == sdc_pkg::ADDR_DIAG) ||
				(addr == sdc_pkg::ADDR_STAT);
		end
	endfunction : access_ok

	function automatic sdc_pkg::sdc_src_type src_of(input logic [1:0] addr);
		if (addr == sdc_pkg::ADDR_DIAG) begin
			src_of = sdc_pkg::SDC_SRC_DIAG;
		end else if (addr == sdc_pkg::ADDR_STAT) begin
			src_of = sdc_pkg::SDC_SRC_STAT;
		end else begin
			src_of = sdc_pkg::SDC_SRC_CMD;
		end
	endfunction : src_of

	// Register body as seen by the host, unused bits zero
	function automatic logic [12:0] body_of(
		input sdc_pkg::sdc_src_type src,
		input sdc_pkg::sdc_core_type s,
		input logic [12:0] diag,
		input logic [6:0] stat
	);
		logic [12:0] b;
		b = 13'h0000;
		case (src)
			sdc_pkg::SDC_SRC_CMD: begin
				b[sdc_pkg::THR_HI:sdc_pkg::THR_LO] = s.thr;
				b[sdc_pkg::LOAD_HI:sdc_pkg::LOAD_LO] = s.load;
				b[sdc_pkg::CH5_POS] = s.ch5;
				b[sdc_pkg::CH4_POS] = s.ch4;
				b[sdc_pkg::CH2_POS] = s.ch2; // see [RULE12]
			end
			sdc_pkg::SDC_SRC_DIAG: begin
				b = diag;
			end
			sdc_pkg::SDC_SRC_STAT: begin
				b[sdc_pkg::STAT_W-1:0] = stat;
			end
			default: begin
				b = 13'h0000;
			end
		endcase
		body_of = b;
	endfunction : body_of

	assign sel_rise = sel_s & ~st.sel_prev;
	assign wd_rise = wd_s & ~st.wd_prev;
	assign wd_active = ~wd_s;
	assign f_rw = rx_word[sdc_pkg::RW_POS];
	assign f_addr = rx_word[sdc_pkg::ADDR_HI:sdc_pkg::ADDR_LO]; // see [RULE23]
	// A frame with no clock leaves the tag untouched, so it cannot reuse an old count
	assign frame_ok = (frame_tag != st.tag_seen) && (bit_cnt == sdc_pkg::CNT_FULL) &&
		access_ok(f_rw, f_addr); // see [RULE3] [RULE7] [RULE9]

	always_comb begin
		next_st = st;
		next_st.sel_prev = sel_s;
		next_st.wd_prev = wd_s;
		if (sel_rise) begin
			// Link data is quiet here: the host keeps the clock low after the frame
			next_st.tag_seen = frame_tag; // see [RULE5]
			if (!wd_active) begin
				if (frame_ok) begin
					if (f_rw) begin
						next_st.thr = rx_word[sdc_pkg::THR_HI:sdc_pkg::THR_LO]; // see [RULE21] [RULE24]
						next_st.load = rx_word[sdc_pkg::LOAD_HI:sdc_pkg::LOAD_LO]; // see [RULE22] [RULE24]
						next_st.ch5 = rx_word[sdc_pkg::CH5_POS]; // see [RULE24]
						next_st.ch4 = rx_word[sdc_pkg::CH4_POS]; // see [RULE24]
						next_st.ch2 = rx_word[sdc_pkg::CH2_POS]; // see [RULE24]
					end
					next_st.reply_rw = f_rw; // see [RULE10]
					next_st.reply_addr = f_addr; // see [RULE10]
					next_st.src = src_of(f_addr); // see [RULE19]
				end else begin
					next_st.reply_rw = 1'b0;
					next_st.reply_addr = sdc_pkg::ADDR_DIAG;
					next_st.src = sdc_pkg::SDC_SRC_DIAG; // see [RULE20]
				end
			end
		end else if (wd_rise) begin
			next_st.reply_rw = 1'b0;
			next_st.reply_addr = sdc_pkg::ADDR_STAT;
			next_st.src = sdc_pkg::SDC_SRC_STAT; // see [RULE18]
		end
		// Reply and flag only move between frames so the link never sees them change
		if (sel_s && st.sel_prev) begin
			next_st.reply = {st.reply_rw, st.reply_addr,
				body_of(st.src, st, diag_s, stat_s)}; // see [RULE8] [RULE10]
			next_st.diag_any = |diag_s; // see [RULE11]
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			st.thr <= sdc_pkg::THR_RESET; // see [RULE14]
			st.load <= sdc_pkg::LOAD_RESET;
			st.ch2 <= sdc_pkg::CH_RESET;
			st.ch4 <= sdc_pkg::CH_RESET;
			st.ch5 <= sdc_pkg::CH_RESET;
			st.src <= sdc_pkg::SDC_SRC_CMD; // see [RULE16]
			st.reply_rw <= 1'b0;
			st.reply_addr <= sdc_pkg::ADDR_CMD;
			st.reply <= sdc_pkg::REPLY_RESET;
			st.sel_prev <= 1'b1;
			st.wd_prev <= 1'b1;
			st.tag_seen <= 1'b0;
			st.diag_any <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Output mux: reset forces low, watchdog reset and frame start show the flag
	always_comb begin
		if (!NRST) begin
			SO_OUT = 1'b0; // see [RULE15]
		end else if (wd_active) begin
			SO_OUT = st.diag_any; // see [RULE17]
		end else if (tx_started) begin
			SO_OUT = tx_bit; // see [RULE4]
		end else begin
			SO_OUT = st.diag_any; // see [RULE2] [RULE11]
		end
	end

	assign SO_OE = ~SELECT_N; // see [RULE1]
	assign CH2_ON = st.ch2;
	assign CH4_ON = st.ch4;
	assign CH5_ON = st.ch5;
	assign SENSOR_THRESHOLD_SEL = st.thr;
	assign SENSOR_LOAD_SEL = st.load;
endmodule : sdc_slave
`default_nettype wire

//--- verilog/sdc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sdc_sync_type;

	sdc_sync_type st;
	sdc_sync_type next_st;

	// First stage is read only by the second stage
	always_comb begin
		next_st = st;
		next_st.meta = d;
		next_st.stable = st.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= {RST_VAL, RST_VAL};
		end else begin
			st <= next_st;
		end
	end

	assign q = st.stable;
endmodule : sdc_sync
`default_nettype wire
